// ---- src/opfield_pkg.sv ----
// Purpose: Shared constants and types for the operand field decoder.
// Assumes: AHB-Lite register access, 32-bit data, one word per register.
// Notes: Segment and state encodings live here only.
package opfield_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_BYTE = 8'h00;
  localparam logic [7:0] OFS_DECODE = 8'h04;
  localparam logic [7:0] OFS_DISP = 8'h08;
  localparam logic [7:0] OFS_CPU = 8'h0C;
  localparam logic [7:0] OFS_EA = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_COND = 8'h18;

  // ==========================================================
  // Register field positions
  localparam int CPU_SI_LSB = 16;
  localparam int FLG_ZERO_BIT = 0;
  localparam int FLG_CARRY_BIT = 1;
  localparam int FLG_SIGN_BIT = 2;
  localparam int FLG_OVF_BIT = 3;
  localparam int FLG_COUNT_LSB = 4;

  // ==========================================================
  // Instruction field encodings
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [7:0] PFX_MASK = 8'hE7;
  localparam logic [7:0] PFX_MATCH = 8'h26;
  localparam int PFX_SEG_LSB = 3;
  localparam int OPC_DIR_BIT = 1;
  localparam int OPC_WIDTH_BIT = 0;
  localparam int OPC_COUNT_BIT = 1;
  localparam int OPC_SENSE_BIT = 0;
  localparam logic [2:0] RM_BASE_SRC = 3'h0;
  localparam logic [7:0] SHIFT_ONE = 8'h01;
  localparam logic [15:0] DISP_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    SEG_EXTRA = 2'h0,
    SEG_CODE = 2'h1,
    SEG_STACK = 2'h2,
    SEG_DATA = 2'h3
  } seg_t;

  typedef enum logic [1:0] {
    ST_OPCODE = 2'h0,
    ST_MODRM = 2'h1,
    ST_DISP_LO = 2'h3,
    ST_DISP_HI = 2'h2
  } dec_state_t;

  // Register selector: bit 3 set picks the word set, clear the byte set
  typedef struct packed {
    logic word_op;
    logic dir_to_reg;
    logic mem_access;
    logic [1:0] mode;
    logic [3:0] dest_sel;
    logic [3:0] src_sel;
    logic seg_ovr;
    seg_t seg;
    logic count_from_reg;
    logic repeat_sense;
    logic [15:0] displacement;
    logic [15:0] effective_address;
    logic ea_valid;
  } decode_t;

  typedef struct packed {
    logic zero_flag;
    logic carry;
    logic sign;
    logic overflow;
    logic [7:0] count_low_byte;
  } flags_t;

  typedef struct packed {
    logic [7:0] shift_count;
    logic rep_continue;
    logic above;
    logic below;
    logic greater;
    logic less;
  } cond_t;

endpackage

// ---- src/cond_eval.sv ----
// Purpose: Condition, shift count and repeat evaluation from live flags.
// Assumes: Flags and count byte supplied by the register file.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module cond_eval (
  input wire opfield_pkg::flags_t flags_i,
  input wire logic count_from_reg_i,
  input wire logic repeat_sense_i,
  output opfield_pkg::cond_t cond_o
);
  import opfield_pkg::*;

  always_comb begin
    cond_o = '0;
    // ==========================================================
    // Shift count source
    if (count_from_reg_i) begin
      cond_o.shift_count = flags_i.count_low_byte; // RL7
    end else begin
      cond_o.shift_count = SHIFT_ONE; // RL7
    end
    // ==========================================================
    // Repeat continues while the zero flag matches the sense bit
    cond_o.rep_continue = (flags_i.zero_flag == repeat_sense_i); // RL8
    // ==========================================================
    // Unsigned relations after a compare
    cond_o.above = !flags_i.carry && !flags_i.zero_flag; // RL11
    cond_o.below = flags_i.carry; // RL11
    // Signed relations: greater means more positive
    cond_o.greater = !flags_i.zero_flag && (flags_i.sign == flags_i.overflow); // RL11
    cond_o.less = (flags_i.sign != flags_i.overflow); // RL11
  end

endmodule

// ---- src/opfield_decoder.sv ----
// Purpose: Operand field decoder behind an AHB-Lite register slave.
// Assumes: Instruction bytes are pushed one per write, in stream order.
// Notes: Every instruction is prefix*, opcode, mode byte, then zero to two displacement bytes.
// Contract
// RL1 - Direction bit 1 makes the register field the destination, 0 the source.
// RL2 - Width bit 1 means word operation; 0 means byte with byte registers.
// RL3 - Mode 11 treats rm as a second register, no memory access.
// RL4 - Mode 00 gives zero displacement and no displacement bytes.
// RL5 - Mode 01 takes one byte, sign-extended to sixteen bits.
// RL6 - Mode 10 takes two bytes, low first, second is upper half.
// RL7 - Count bit 0 gives shift count one; 1 uses count low byte.
// RL8 - Compare-sense bit versus zero flag decides whether repetition continues.
// RL9 - Register code decodes by width; 000 is accumulator word or low byte.
// RL10 - Prefix 001ss110; segment 00 extra, 01 code, 10 stack.
// RL11 - Above and below are unsigned; greater and less are signed.
// RL12 - Memory mode with rm 000: address is base plus source index plus displacement.
// RL13 - Don't-care bits never change the decoded controls.
`timescale 1ns/100ps
module opfield_decoder #(
  parameter int ADDR_W = 8
) (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic HSEL_I,
  input wire logic [ADDR_W-1:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output opfield_pkg::decode_t DECODE_O,
  output logic DECODE_VALID_O,
  output opfield_pkg::cond_t COND_O
);
  import opfield_pkg::*;

  // ==========================================================
  // Elaboration check
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must cover the register map and fit 32 bits");
  end

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic ph_valid;
    logic ph_write;
    logic [ADDR_W-1:0] ph_addr;
    dec_state_t st;
    logic [7:0] opc;
    logic [7:0] modrm;
    logic [7:0] disp_lo;
    logic pfx_seen;
    seg_t pfx_seg;
    decode_t dec;
    logic dec_valid;
    logic [15:0] base_word;
    logic [15:0] src_index;
    flags_t flags;
    cond_t cond;
    logic [31:0] rdata;
    logic hresp;
    logic hready;
  } state_t;

  state_t q;
  state_t d;
  cond_t cond_now;

  // ==========================================================
  // Field helpers
  function automatic logic [1:0] mode_of(input logic [7:0] mb);
    return mb[7:6];
  endfunction

  function automatic logic [2:0] regf_of(input logic [7:0] mb);
    return mb[5:3];
  endfunction

  function automatic logic [2:0] rm_of(input logic [7:0] mb);
    return mb[2:0];
  endfunction

  // Selector carries the width so byte and word sets never alias
  function automatic logic [3:0] reg_sel(input logic w, input logic [2:0] code);
    return {w, code}; // RL2 RL9
  endfunction

  function automatic logic [15:0] sext8(input logic [7:0] b);
    return {{8{b[7]}}, b}; // RL5
  endfunction

  // Low byte arrives first, so the later byte is the upper half
  function automatic logic [15:0] disp16(input logic [7:0] lo, input logic [7:0] hi);
    return {hi, lo}; // RL6
  endfunction

  // The match ignores only the two segment bits of a prefix
  function automatic logic is_prefix(input logic [7:0] b);
    return (b & PFX_MASK) == PFX_MATCH; // RL10 RL13
  endfunction

  function automatic seg_t seg_of(input logic [7:0] b);
    return seg_t'(b[PFX_SEG_LSB +: 2]); // RL10
  endfunction

  // ==========================================================
  // Build the decoded controls once all bytes are in
  // Wraps at sixteen bits, as the address adder does
  function automatic logic [15:0] ea_of(input logic [15:0] base, input logic [15:0] sidx,
    input logic [15:0] disp);
    return 16'(base + sidx + disp); // RL12
  endfunction

  function automatic decode_t build(
    input logic [7:0] opc,
    input logic [7:0] mb,
    input logic [15:0] disp,
    input logic pfx,
    input seg_t pseg,
    input logic [15:0] base,
    input logic [15:0] sidx
  );
    decode_t r;
    logic w;
    logic [3:0] regf_sel;
    logic [3:0] rm_sel;
    r = '0;
    w = opc[OPC_WIDTH_BIT];
    regf_sel = reg_sel(w, regf_of(mb));
    r.word_op = w; // RL2
    r.dir_to_reg = opc[OPC_DIR_BIT];
    r.mode = mode_of(mb);
    r.count_from_reg = opc[OPC_COUNT_BIT];
    r.repeat_sense = opc[OPC_SENSE_BIT];
    r.seg_ovr = pfx;
    // Segment field is meaningless without a prefix
    r.seg = pfx ? pseg : SEG_DATA; // RL13
    if (mode_of(mb) == MOD_REG) begin
      rm_sel = reg_sel(w, rm_of(mb)); // RL3
      r.mem_access = 1'b0; // RL3
      r.displacement = DISP_ZERO;
    end else begin
      rm_sel = '0;
      r.mem_access = 1'b1;
      r.displacement = disp;
    end
    if (opc[OPC_DIR_BIT]) begin
      r.dest_sel = regf_sel; // RL1
      r.src_sel = rm_sel; // RL1
    end else begin
      r.dest_sel = rm_sel; // RL1
      r.src_sel = regf_sel; // RL1
    end
    if (r.mem_access && rm_of(mb) == RM_BASE_SRC) begin
      r.effective_address = ea_of(base, sidx, disp); // RL12
      r.ea_valid = 1'b1;
    end
    return r;
  endfunction

  // ==========================================================
  // Register read mux
  // Flags layout is shared by the read and the write path
  function automatic flags_t flags_from_word(input logic [31:0] w);
    flags_t f;
    f.zero_flag = w[FLG_ZERO_BIT];
    f.carry = w[FLG_CARRY_BIT];
    f.sign = w[FLG_SIGN_BIT];
    f.overflow = w[FLG_OVF_BIT];
    f.count_low_byte = w[FLG_COUNT_LSB +: 8];
    return f;
  endfunction

  function automatic logic [31:0] word_from_flags(input flags_t f);
    logic [31:0] w;
    w = '0;
    w[FLG_ZERO_BIT] = f.zero_flag;
    w[FLG_CARRY_BIT] = f.carry;
    w[FLG_SIGN_BIT] = f.sign;
    w[FLG_OVF_BIT] = f.overflow;
    w[FLG_COUNT_LSB +: 8] = f.count_low_byte;
    return w;
  endfunction

  function automatic logic [31:0] word_from_decode(input decode_t c);
    return {14'h0000, c.count_from_reg, c.repeat_sense, c.seg_ovr, c.seg, c.src_sel,
            c.dest_sel, c.mode, c.mem_access, c.dir_to_reg, c.word_op};
  endfunction

  function automatic logic [31:0] word_from_cond(input cond_t c);
    return {19'h00000, c.shift_count, c.less, c.greater, c.below, c.above, c.rep_continue};
  endfunction

  function automatic logic [31:0] read_word(input state_t s, input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    if (a == ADDR_W'(OFS_BYTE)) begin
      v = {24'h000000, 2'h0, s.pfx_seg, s.pfx_seen, s.st, s.dec_valid};
    end else if (a == ADDR_W'(OFS_DECODE)) begin
      v = word_from_decode(s.dec);
    end else if (a == ADDR_W'(OFS_DISP)) begin
      v = {16'h0000, s.dec.displacement};
    end else if (a == ADDR_W'(OFS_CPU)) begin
      v = {s.src_index, s.base_word};
    end else if (a == ADDR_W'(OFS_EA)) begin
      v = {15'h0000, s.dec.ea_valid, s.dec.effective_address};
    end else if (a == ADDR_W'(OFS_FLAGS)) begin
      v = word_from_flags(s.flags);
    end else if (a == ADDR_W'(OFS_COND)) begin
      v = word_from_cond(s.cond);
    end
    return v;
  endfunction

  // ==========================================================
  // Condition evaluation on the live flags
  cond_eval u_cond (
    .flags_i(q.flags),
    .count_from_reg_i(q.dec.count_from_reg),
    .repeat_sense_i(q.dec.repeat_sense),
    .cond_o(cond_now)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] b;
    logic accept;
    logic do_write;
    b = HWDATA_I[7:0];
    d = q;
    d.cond = cond_now;
    // Only OKAY is ever answered, yet it still leaves a flop
    d.hresp = 1'b0;
    accept = HSEL_I && HTRANS_I[1] && HREADY_I;
    do_write = q.ph_valid && q.ph_write;

    // Data phase of a write: apply it
    if (do_write) begin
      d.ph_valid = 1'b0;
      if (q.ph_addr == ADDR_W'(OFS_BYTE)) begin
        case (q.st)
          ST_OPCODE: begin
            // Prefixes may repeat; the last one wins
            if (is_prefix(b)) begin
              d.pfx_seen = 1'b1;
              d.pfx_seg = seg_of(b);
            end else begin
              d.opc = b;
              d.dec_valid = 1'b0;
              d.st = ST_MODRM;
            end
          end
          ST_MODRM: begin
            d.modrm = b;
            if (mode_of(b) == MOD_DISP8 || mode_of(b) == MOD_DISP16) begin
              d.st = ST_DISP_LO;
            end else begin
              // Mode 00 and 11 carry no displacement bytes
              d.dec = build(q.opc, b, DISP_ZERO, q.pfx_seen, q.pfx_seg,
                            q.base_word, q.src_index); // RL4
              d.dec_valid = 1'b1;
              d.pfx_seen = 1'b0;
              d.st = ST_OPCODE;
            end
          end
          ST_DISP_LO: begin
            d.disp_lo = b;
            if (mode_of(q.modrm) == MOD_DISP8) begin
              d.dec = build(q.opc, q.modrm, sext8(b), q.pfx_seen, q.pfx_seg,
                            q.base_word, q.src_index); // RL5
              d.dec_valid = 1'b1;
              d.pfx_seen = 1'b0;
              d.st = ST_OPCODE;
            end else begin
              d.st = ST_DISP_HI; // RL6
            end
          end
          ST_DISP_HI: begin
            d.dec = build(q.opc, q.modrm, disp16(q.disp_lo, b), q.pfx_seen, q.pfx_seg,
                          q.base_word, q.src_index); // RL6
            d.dec_valid = 1'b1;
            d.pfx_seen = 1'b0;
            d.st = ST_OPCODE;
          end
          default: begin
            d.st = ST_OPCODE;
          end
        endcase
      end else if (q.ph_addr == ADDR_W'(OFS_DECODE)) begin
        // Abort a partial instruction and drop the last result
        d.st = ST_OPCODE;
        d.pfx_seen = 1'b0;
        d.dec_valid = 1'b0;
      end else if (q.ph_addr == ADDR_W'(OFS_CPU)) begin
        d.base_word = HWDATA_I[15:0];
        d.src_index = HWDATA_I[CPU_SI_LSB +: 16];
      end else if (q.ph_addr == ADDR_W'(OFS_FLAGS)) begin
        d.flags = flags_from_word(HWDATA_I);
      end
    end

    // Reads wait one cycle so a read right after a write sees it
    if (q.ph_valid && !q.ph_write) begin
      d.rdata = read_word(q, q.ph_addr);
      d.hready = 1'b1;
      d.ph_valid = 1'b0;
    end

    // Address phase
    if (accept) begin
      d.ph_valid = 1'b1;
      d.ph_write = HWRITE_I;
      // Word aligned: the low address bits never select a register
      d.ph_addr = {HADDR_I[ADDR_W-1:2], 2'h0};
      if (!HWRITE_I) begin
        d.hready = 1'b0;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      // The bus must see ready as soon as reset lifts
      q <= '0;
      q.hready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign HRDATA_O = q.rdata;
  assign HREADYOUT_O = q.hready;
  assign HRESP_O = q.hresp;
  assign DECODE_O = q.dec;
  assign DECODE_VALID_O = q.dec_valid;
  assign COND_O = q.cond;

  // HSIZE is not checked: only whole-word transfers are supported
  logic unused_size;
  assign unused_size = ^HSIZE_I;

endmodule

// ---- bench/opfield_decoder_asserts.sv ----
// Purpose: Port-level checks of the operand field decoder.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Decode field checks apply only while a decode is flagged valid; the shift count check applies whenever count_from_reg is clear for two samples.
`timescale 1ns/100ps
module opfield_decoder_asserts (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic HSEL_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic HREADY_I,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire opfield_pkg::decode_t DECODE_O,
  input wire logic DECODE_VALID_O,
  input wire opfield_pkg::cond_t COND_O
);
  import opfield_pkg::*;
  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  sequence rd_req;
    HSEL_I && HTRANS_I[1] && !HWRITE_I && HREADY_I;
  endsequence
  sequence one_wait;
    !HREADYOUT_O ##1 HREADYOUT_O;
  endsequence
  a_resp_okay: assert property (HRESP_O == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (rd_req |=> one_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (HSEL_I && HTRANS_I[1] && HWRITE_I && HREADY_I |=> HREADYOUT_O)
    else $error("write stalled");
  a_reg_nomem: assert property (DECODE_VALID_O && DECODE_O.mode == MOD_REG
    |-> !DECODE_O.mem_access)
    else $error("register mode accesses memory");
  a_mem_mode: assert property (DECODE_VALID_O && DECODE_O.mode != MOD_REG
    |-> DECODE_O.mem_access)
    else $error("memory mode without access");
  a_nodisp_zero: assert property (DECODE_VALID_O && DECODE_O.mode == MOD_NODISP
    |-> DECODE_O.displacement == DISP_ZERO)
    else $error("mode 00 displacement not zero");
  a_disp8_sext: assert property (DECODE_VALID_O && DECODE_O.mode == MOD_DISP8
    |-> DECODE_O.displacement[15:8] == {8{DECODE_O.displacement[7]}})
    else $error("byte displacement not sign extended");
  a_sel_width: assert property (DECODE_VALID_O && DECODE_O.mode == MOD_REG
    |-> DECODE_O.dest_sel[3] == DECODE_O.word_op
    && DECODE_O.src_sel[3] == DECODE_O.word_op)
    else $error("register set does not follow width");
  // Both samples out of reset, so the lagging condition word is settled
  a_shift_one: assert property ((ARST_N_I && !DECODE_O.count_from_reg) [*2]
    |-> COND_O.shift_count == SHIFT_ONE)
    else $error("shift count not one");
endmodule
bind opfield_decoder opfield_decoder_asserts u_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
  .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
  .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .DECODE_O(DECODE_O),
  .DECODE_VALID_O(DECODE_VALID_O), .COND_O(COND_O));

// ---- bench/fetch_model.sv ----
// Purpose: Program fetch model serialising one instruction into bytes.
// Assumes: Segment code 11 is never asked for.
// Notes: Past the end the byte changes with the index, so stale reuse shows.
`timescale 1ns/100ps
module fetch_model (
  input wire logic pfx_en_i,
  input wire logic [1:0] seg_i,
  input wire logic [7:0] opc_i,
  input wire logic [7:0] modrm_i,
  input wire logic [15:0] disp_i,
  input wire logic [2:0] idx_i,
  output logic [7:0] byte_o,
  output logic [2:0] len_o
);
  import opfield_pkg::*;
  // ==========================================================
  // Stream order
  logic [7:0] strm [6];
  logic [2:0] pos;
  always_comb begin
    strm[0] = PFX_MATCH | {3'h0, seg_i, 3'h0};
    strm[1] = opc_i;
    strm[2] = modrm_i;
    strm[3] = disp_i[7:0];
    strm[4] = disp_i[15:8];
    strm[5] = 8'h00;
    len_o = {2'h0, pfx_en_i} + 3'h2;
    if (modrm_i[7:6] == MOD_DISP8) begin
      len_o = len_o + 3'h1;
    end else if (modrm_i[7:6] == MOD_DISP16) begin
      len_o = len_o + 3'h2;
    end
    pos = idx_i + {2'h0, !pfx_en_i};
    byte_o = (idx_i < len_o) ? strm[pos] : 8'h5A ^ {5'h0, idx_i};
  end
endmodule

// ---- bench/opfield_decoder_tb.sv ----
// Purpose: Self-checking bench for the operand field decoder.
// Assumes: Single AHB-Lite slave, so hready is its own hreadyout.
// Notes: Random instructions from a fixed seed with forced corner cases.
`timescale 1ns/100ps
module opfield_decoder_tb;
  import opfield_pkg::*;
  // ==========================================================
  // Signals and instances
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  decode_t dec;
  logic dec_valid;
  cond_t cond;
  logic pe = 1'b0;
  logic [1:0] sg = 2'h0;
  logic [7:0] opc = 8'h00;
  logic [7:0] mrm = 8'h00;
  logic [15:0] dsp = 16'h0;
  logic [2:0] idx = 3'h0;
  logic [7:0] sbyte;
  logic [2:0] slen;
  logic [31:0] seed = 32'h42EE;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  opfield_decoder u_dut (.CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(1'b1), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .DECODE_O(dec),
    .DECODE_VALID_O(dec_valid), .COND_O(cond));
  fetch_model u_src (.pfx_en_i(pe), .seg_i(sg), .opc_i(opc), .modrm_i(mrm), .disp_i(dsp),
    .idx_i(idx), .byte_o(sbyte), .len_o(slen));
  initial begin
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] disp_of(input logic [1:0] md, input logic [15:0] d);
    case (md)
      MOD_DISP8: return {{8{d[7]}}, d[7:0]};
      MOD_DISP16: return d;
      default: return DISP_ZERO;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Hready sampled at the negedge holds what the next rising edge sees
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(negedge clk); while (hready !== 1'b1);
    @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      final_report();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] rd;
    logic [15:0] base;
    logic [15:0] si;
    logic [15:0] ea;
    logic [11:0] f;
    logic [3:0] rg;
    logic [3:0] rs;
    logic [1:0] md;
    logic w;
    logic d;
    cond_t ec;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    chk(hrdata, 32'h0);
    for (int i = 0; i < 24; i++) begin
      repeat (32) seed = lfsr(seed);
      base = seed[15:0];
      si = seed[31:16];
      ahb(1'b1, OFS_CPU, seed, rd);
      repeat (32) seed = lfsr(seed);
      pe <= (i < 3) | seed[0];
      sg <= (i < 3) ? 2'(i) : (seed[2:1] == 2'h3 ? 2'h1 : seed[2:1]);
      opc <= ((seed[15:8] & PFX_MASK) == PFX_MATCH) ? seed[15:8] ^ 8'h80 : seed[15:8];
      mrm <= {2'(i), seed[21:19], ((i < 4) ? RM_BASE_SRC : seed[18:16])};
      dsp <= (i < 4) ? 16'h80FF : seed[31:16];
      @(negedge clk);
      for (int k = 0; k < 32'(slen); k++) begin
        idx <= 3'(k);
        @(negedge clk);
        ahb(1'b1, OFS_BYTE, 32'(sbyte), rd);
      end
      @(posedge clk);
      @(negedge clk);
      w = opc[0];
      d = opc[1];
      md = mrm[7:6];
      rg = {w, mrm[5:3]};
      rs = (md == MOD_REG) ? {w, mrm[2:0]} : 4'h0;
      ea = base + si + disp_of(md, dsp);
      chk(32'(dec_valid), 32'h1);
      chk(32'({dec.word_op, dec.dir_to_reg, dec.mode}), 32'({w, d, md}));
      chk(32'(dec.mem_access), 32'(md != MOD_REG));
      chk(32'({dec.dest_sel, dec.src_sel}), 32'(d ? {rg, rs} : {rs, rg}));
      chk(32'({dec.seg_ovr, dec.seg}), 32'(pe ? {1'b1, sg} : {1'b0, SEG_DATA}));
      chk(32'({dec.count_from_reg, dec.repeat_sense}), 32'(opc[1:0]));
      if (md != MOD_REG) begin
        ahb(1'b0, OFS_DISP, 32'h0, rd);
        chk(32'(rd[15:0]), 32'(disp_of(md, dsp)));
      end
      if (md != MOD_REG && mrm[2:0] == RM_BASE_SRC) begin
        chk(32'({dec.ea_valid, dec.effective_address}), {15'h0000, 1'b1, ea});
      end
      repeat (32) seed = lfsr(seed);
      f = seed[11:0];
      ahb(1'b1, OFS_FLAGS, 32'(f), rd);
      repeat (2) @(posedge clk);
      @(negedge clk);
      ec.shift_count = d ? f[11:4] : SHIFT_ONE;
      ec.rep_continue = f[0] == opc[0];
      ec.above = !f[1] && !f[0];
      ec.below = f[1];
      ec.greater = !f[0] && (f[2] == f[3]);
      ec.less = f[2] != f[3];
      chk(32'(cond), 32'(ec));
      ahb(1'b0, OFS_FLAGS, 32'h0, rd);
      chk(rd, 32'(f));
      ahb(1'b1, OFS_DECODE, seed, rd);
      ahb(1'b0, 8'h1C, 32'h0, rd);
      chk(rd, 32'h0);
      chk(32'(dec_valid), 32'h0);
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule
